// ---- rtl/residual_overcurrent_defs.vh ----
// constants for the residual overcurrent trip timer
// Function
// - only fundamental residual magnitude drives timing
// - start above pickup, trip after delay
// - modes Off, fixed, four IEC, seven ANSI
// - pickup percent, default 50, range by variant
// - multiplier 0.05 to 15, default 1.0
// - inverse minimum delay 40..60000 ms
// - fixed delay 40..60000 ms, fixed mode only
// - IEC curves clear after reset delay
// - block input suppresses start and trip
// - general start and trip combine block
// - inverse time per curve constants
// - ratio above twenty held at twenty
// - inverse trip needs curve and minimum expiry
`ifndef RESIDUAL_OVERCURRENT_DEFS_VH
`define RESIDUAL_OVERCURRENT_DEFS_VH

// register byte offsets
`define ROC_OFS_CTRL 8'h00
`define ROC_OFS_PICKUP 8'h04
`define ROC_OFS_TMS 8'h08
`define ROC_OFS_MINDLY 8'h0c
`define ROC_OFS_FIXDLY 8'h10
`define ROC_OFS_RSTDLY 8'h14
`define ROC_OFS_STATUS 8'h18
`define ROC_OFS_ISTAT 8'h1c
`define ROC_OFS_ICLR 8'h20
`define ROC_OFS_IEN 8'h24
`define ROC_OFS_ACC 8'h28

// field positions
`define ROC_CTRL_CURVE_LSB 0
`define ROC_CTRL_CURVE_MSB 3
`define ROC_CTRL_LOWRANGE 4
`define ROC_ST_START 0
`define ROC_ST_TRIP 1
`define ROC_ST_BLOCK 2
`define ROC_ST_GSTART 3
`define ROC_ST_GTRIP 4
`define ROC_IRQ_START 0
`define ROC_IRQ_TRIP 1

// mode codes of curve_select
`define ROC_MODE_OFF 4'h0
`define ROC_MODE_FIXED 4'h1
`define ROC_MODE_FIRST_INV 4'h2
`define ROC_MODE_LAST_IEC 4'h5
`define ROC_MODE_LAST_INV 4'hc

// reset values
`define ROC_RST_PICKUP 10'h032
`define ROC_RST_TMS 11'h064
`define ROC_RST_DELAY 16'h0064

// setting ranges
`define ROC_PICKUP_MIN 16'h000a
`define ROC_PICKUP_MIN_LOW 16'h0005
`define ROC_PICKUP_MAX 16'h03e8
`define ROC_TMS_MIN 16'h0005
`define ROC_TMS_MAX 16'h05dc
`define ROC_DLY_MIN 16'h0028
`define ROC_RSTDLY_MIN 16'h003c
`define ROC_DLY_MAX 16'hea60

// timing: one processing tick per millisecond
`define ROC_CLK_NS 50
`define ROC_TICK_NS 1000000
`define ROC_TICK_CYCLES (`ROC_TICK_NS / `ROC_CLK_NS)

// fixed point scaling
`define ROC_Q16_ONE 32'h00010000
`define ROC_RATIO_ONE 13'h0100
`define ROC_RATIO_MAX 13'h1400
`define ROC_LN_SCALE 32'h0000038c
`define ROC_RATE_SCALE 32'h0a000000
`define ROC_TMS_UNIT 18'h28f5c

`endif

// ---- rtl/serial_divider.v ----
// serial restoring divider, one quotient bit per clock
module serial_divider #(
    parameter W = 64
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // request
    input wire go,
    input wire [W-1:0] num,
    input wire [W-1:0] den,
    // answer
    output reg [W-1:0] quot,
    output reg done
);
    reg [W-1:0] rem_q;
    reg [7:0] cnt_q;
    wire [W-1:0] trial = {rem_q[W-2:0], quot[W-1]};
    wire [W:0] diff = {1'b0, trial} - {1'b0, den};

    // a zero divisor yields all ones, which the caller saturates
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rem_q <= {W{1'b0}};
            quot <= {W{1'b0}};
            cnt_q <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) begin
                rem_q <= {W{1'b0}};
                quot <= num;
                cnt_q <= W[7:0];
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
                done <= (cnt_q == 8'h01);
                if (!diff[W]) begin
                    rem_q <= diff[W-1:0];
                    quot <= {quot[W-2:0], 1'b1};
                end else begin
                    rem_q <= trial;
                    quot <= {quot[W-2:0], 1'b0};
                end
            end
        end
    end
endmodule // serial_divider

// ---- rtl/residual_overcurrent_trip_timer.v ----
// residual overcurrent start/trip timer with apb settings and interrupt
//
// The address map and register access over APB are this design's own decisions.
`include "residual_overcurrent_defs.vh"
module residual_overcurrent_trip_timer #(
    parameter TICK_CYCLES = `ROC_TICK_CYCLES
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // measurement, same clock, percent of rated current in q4
    input wire [15:0] residualFundamentalMag,
    // user blocking pin
    input wire blockInput,
    // decision outputs
    output reg startFlag,
    output reg tripFlag,
    output reg generalStartOut,
    output reg generalTripOut,
    output reg irq
);
    localparam S_IDLE = 3'b001;
    localparam S_RATIO = 3'b010;
    localparam S_RATE = 3'b100;

    // settings
    reg [3:0] curveSel_q;
    reg lowRange_q;
    reg [9:0] pickup_q;
    reg [10:0] tms_q;
    reg [15:0] minDly_q, fixDly_q, rstDly_q;
    reg [1:0] istat_q, ien_q;
    // timing state
    reg [2:0] state_q;
    reg [31:0] acc_q;
    reg [15:0] minCnt_q, defCnt_q, rstCnt_q;
    reg [14:0] tickCnt_q;
    reg tick_q, dirUp_q;
    reg [2:0] blkSync_q;
    reg blocked_q;
    reg divGo_q;
    reg [63:0] divNum_q, divDen_q;
    wire [63:0] divQuot;
    wire divDone;

    // clamp a written value into its setting range
    function [15:0] clampVal(input [31:0] v, input [15:0] lo, input [15:0] hi);
        begin
            if (v < {16'h0000, lo})
                clampVal = lo;
            else if (v > {16'h0000, hi})
                clampVal = hi;
            else
                clampVal = v[15:0];
        end
    endfunction

    function isInverse(input [3:0] s);
        isInverse = (s >= `ROC_MODE_FIRST_INV) && (s <= `ROC_MODE_LAST_INV);
    endfunction

    function isFixedReset(input [3:0] s);
        isFixedReset = (s >= `ROC_MODE_FIRST_INV) && (s <= `ROC_MODE_LAST_IEC);
    endfunction

    // curve constants in 0.1 ms: {kr, c, reset kr, alpha code}
    function [68:0] curveConst(input [3:0] s);
        case (s)
            4'h2: curveConst = {21'd1400, 13'd0, 33'd0, 2'd0};
            4'h3: curveConst = {21'd135000, 13'd0, 33'd0, 2'd1};
            4'h4: curveConst = {21'd800000, 13'd0, 33'd0, 2'd2};
            4'h5: curveConst = {21'd1200000, 13'd0, 33'd0, 2'd1};
            4'h6: curveConst = {21'd86, 13'd185, 33'd4600, 2'd0};
            4'h7: curveConst = {21'd515, 13'd1140, 33'd48500, 2'd0};
            4'h8: curveConst = {21'd196100, 13'd4910, 33'd216000, 2'd2};
            4'h9: curveConst = {21'd282000, 13'd1217, 33'd291000, 2'd2};
            4'ha: curveConst = {21'd860, 13'd1850, 33'd46000, 2'd0};
            4'hb: curveConst = {21'd285500, 13'd7120, 33'd134600, 2'd2};
            4'hc: curveConst = {21'd640700, 13'd2500, 33'd300000, 2'd2};
            default: curveConst = 69'd0;
        endcase
    endfunction

    // ratio^alpha - 1 in q16 from a q8 ratio; alpha 0.02 uses 0.02*ln
    function [31:0] curveX(input [1:0] a, input [12:0] m);
        integer i;
        reg [31:0] p, lg, mm;
        begin
            p = 32'd8;
            mm = {19'd0, m};
            for (i = 8; i < 13; i = i + 1)
                if (m[i])
                    p = i;
            lg = ((p - 32'd8) << 16) + ((mm - (32'd1 << p)) << (32'd16 - p));
            case (a)
                2'd2: curveX = mm * mm - `ROC_Q16_ONE;
                2'd1: curveX = (mm - 32'd256) << 8;
                default: curveX = (lg * `ROC_LN_SCALE) >> 16;
            endcase
        end
    endfunction

    // quotient from the divider, saturated to the accumulator width
    wire [31:0] divSat = (divQuot[63:32] != 32'd0) ? 32'hffffffff : divQuot[31:0];
    wire [68:0] cc = curveConst(curveSel_q);
    wire [20:0] crvKr = cc[68:48];
    wire [12:0] crvC = cc[47:35];
    wire [32:0] crvRkr = cc[34:2];
    wire [1:0] crvAlpha = cc[1:0];
    wire [12:0] ratioQ8 = (divQuot > {51'd0, `ROC_RATIO_MAX}) ? `ROC_RATIO_MAX : divQuot[12:0];
    wire [31:0] xVal = curveX(crvAlpha, ratioQ8);
    wire [31:0] sqVal = {19'd0, ratioQ8} * {19'd0, ratioQ8};
    wire [31:0] thr = {21'd0, tms_q} * {14'd0, `ROC_TMS_UNIT};
    wire modeOn = (curveSel_q != `ROC_MODE_OFF);
    // only the fundamental magnitude is compared against the pickup
    wire overPickup = residualFundamentalMag > {2'b00, pickup_q, 4'h0};
    wire startInt = modeOn & overPickup & ~blocked_q;
    wire invDone = (acc_q >= thr) && (minCnt_q >= minDly_q);
    wire defDone = (defCnt_q >= fixDly_q);
    wire tripInt = startInt & (isInverse(curveSel_q) ? invDone : defDone);
    wire apbSetup = psel & ~penable;
    wire apbWrite = psel & penable & pready & pwrite;
    wire [15:0] pickClamp = clampVal(pwdata, lowRange_q ? `ROC_PICKUP_MIN_LOW : `ROC_PICKUP_MIN, `ROC_PICKUP_MAX);
    wire [15:0] tmsClamp = clampVal(pwdata, `ROC_TMS_MIN, `ROC_TMS_MAX);
    wire invRun = isInverse(curveSel_q) & ~blocked_q;
    reg [31:0] rdMux;
    reg rdErr;

    serial_divider #(.W(64)) u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .go(divGo_q),
        .num(divNum_q),
        .den(divDen_q),
        .quot(divQuot),
        .done(divDone)
    );

    // read decode, answered in the access phase
    always @* begin
        rdMux = 32'h00000000;
        rdErr = 1'b0;
        case (paddr)
            `ROC_OFS_CTRL: rdMux = {27'd0, lowRange_q, curveSel_q};
            `ROC_OFS_PICKUP: rdMux = {22'd0, pickup_q};
            `ROC_OFS_TMS: rdMux = {21'd0, tms_q};
            `ROC_OFS_MINDLY: rdMux = {16'd0, minDly_q};
            `ROC_OFS_FIXDLY: rdMux = {16'd0, fixDly_q};
            `ROC_OFS_RSTDLY: rdMux = {16'd0, rstDly_q};
            `ROC_OFS_STATUS: rdMux = {27'd0, generalTripOut, generalStartOut, blocked_q, tripFlag, startFlag};
            `ROC_OFS_ISTAT: rdMux = {30'd0, istat_q};
            `ROC_OFS_ICLR: rdMux = 32'h00000000;
            `ROC_OFS_IEN: rdMux = {30'd0, ien_q};
            `ROC_OFS_ACC: rdMux = acc_q;
            default: rdErr = 1'b1;
        endcase
    end

    // apb handshake: zero wait states, data and error registered at setup
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup & rdErr; // only alongside pready
            if (apbSetup)
                prdata <= pwrite ? 32'h00000000 : rdMux;
        end
    end

    // settings registers, values clamped into their ranges on write
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            curveSel_q <= `ROC_MODE_OFF;
            lowRange_q <= 1'b0;
            pickup_q <= `ROC_RST_PICKUP;
            tms_q <= `ROC_RST_TMS;
            minDly_q <= `ROC_RST_DELAY;
            fixDly_q <= `ROC_RST_DELAY;
            rstDly_q <= `ROC_RST_DELAY;
            ien_q <= 2'b00;
        end else if (apbWrite) begin
            case (paddr)
                `ROC_OFS_CTRL: begin
                    // unknown mode codes fall back to off rather than a guessed curve
                    curveSel_q <= (pwdata[3:0] > `ROC_MODE_LAST_INV) ? `ROC_MODE_OFF : pwdata[3:0];
                    lowRange_q <= pwdata[`ROC_CTRL_LOWRANGE];
                end
                `ROC_OFS_PICKUP: pickup_q <= pickClamp[9:0];
                `ROC_OFS_TMS: tms_q <= tmsClamp[10:0];
                `ROC_OFS_MINDLY: minDly_q <= clampVal(pwdata, `ROC_DLY_MIN, `ROC_DLY_MAX);
                `ROC_OFS_FIXDLY: fixDly_q <= clampVal(pwdata, `ROC_DLY_MIN, `ROC_DLY_MAX);
                `ROC_OFS_RSTDLY: rstDly_q <= clampVal(pwdata, `ROC_RSTDLY_MIN, `ROC_DLY_MAX);
                `ROC_OFS_IEN: ien_q <= pwdata[1:0];
                default: ien_q <= ien_q;
            endcase
        end
    end

    // block pin synchroniser: a change counts once stages two and three agree
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blkSync_q <= 3'b000;
            blocked_q <= 1'b0;
        end else begin
            blkSync_q <= {blkSync_q[1:0], blockInput};
            if (blkSync_q[1] == blkSync_q[2])
                blocked_q <= blkSync_q[2];
        end
    end

    // millisecond processing tick
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= 15'd0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tickCnt_q == TICK_CYCLES - 1);
            tickCnt_q <= (tickCnt_q == TICK_CYCLES - 1) ? 15'd0 : tickCnt_q + 15'd1;
        end
    end

    // timers and inverse accumulation; two divisions per tick fit easily
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            acc_q <= 32'd0;
            minCnt_q <= 16'd0;
            defCnt_q <= 16'd0;
            rstCnt_q <= 16'd0;
            dirUp_q <= 1'b0;
            divGo_q <= 1'b0;
            divNum_q <= 64'd0;
            divDen_q <= 64'd0;
        end else begin
            divGo_q <= 1'b0;
            if (!startInt) begin
                minCnt_q <= 16'd0;
                defCnt_q <= 16'd0;
            end else if (tick_q) begin
                if (minCnt_q != 16'hffff)
                    minCnt_q <= minCnt_q + 16'd1;
                if (defCnt_q != 16'hffff)
                    defCnt_q <= defCnt_q + 16'd1;
            end
            // fixed reset: hold accumulated time until dropout lasts the reset delay
            if (startInt || !isFixedReset(curveSel_q) || acc_q == 32'd0)
                rstCnt_q <= 16'd0;
            else if (tick_q) begin
                rstCnt_q <= rstCnt_q + 16'd1;
                if (rstCnt_q + 16'd1 >= rstDly_q)
                    acc_q <= 32'd0;
            end
            case (state_q)
                S_IDLE: begin
                    if (invRun && tick_q && (startInt || (!isFixedReset(curveSel_q) && acc_q != 32'd0))) begin
                        dirUp_q <= startInt;
                        divNum_q <= {44'd0, residualFundamentalMag, 4'h0};
                        divDen_q <= {54'd0, pickup_q};
                        divGo_q <= 1'b1;
                        state_q <= S_RATIO;
                    end
                end
                S_RATIO: if (divDone) begin
                    if (dirUp_q) begin
                        // progress per tick = 10 / t(G) in 0.1 ms units, q24
                        divNum_q <= {32'd0, xVal} * {32'd0, `ROC_RATE_SCALE};
                        divDen_q <= {27'd0, crvKr, 16'h0000} + {51'd0, crvC} * {32'd0, xVal};
                    end else begin
                        // inverse reset rate (1 - ratio^2) / kr_reset, dropped once ratio reaches one
                        divNum_q <= (ratioQ8 >= `ROC_RATIO_ONE) ? 64'd0
                            : {32'd0, `ROC_Q16_ONE - sqVal} * {32'd0, `ROC_RATE_SCALE};
                        divDen_q <= {15'd0, crvRkr, 16'h0000};
                    end
                    divGo_q <= 1'b1;
                    state_q <= S_RATE;
                end
                S_RATE: if (divDone) begin
                    if (dirUp_q)
                        acc_q <= ({1'b0, acc_q} + {1'b0, divSat} >= {1'b0, thr}) ? thr : acc_q + divSat;
                    else
                        acc_q <= (acc_q > divSat) ? acc_q - divSat : 32'd0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
            // cleared in any state, so a division result that lands while blocked is discarded; one in flight when a short block ends still lands
            if (!invRun)
                acc_q <= 32'd0;
        end
    end

    // decision stage and sticky interrupt status; a new event beats a clear
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startFlag <= 1'b0;
            tripFlag <= 1'b0;
            generalStartOut <= 1'b0;
            generalTripOut <= 1'b0;
            istat_q <= 2'b00;
            irq <= 1'b0;
        end else begin
            startFlag <= startInt;
            tripFlag <= tripInt;
            generalStartOut <= startInt & ~blocked_q;
            generalTripOut <= tripInt & ~blocked_q;
            istat_q <= (istat_q & ~((apbWrite && paddr == `ROC_OFS_ICLR) ? pwdata[1:0] : 2'b00))
                | {tripInt & ~tripFlag, startInt & ~startFlag};
            irq <= |(istat_q & ien_q);
        end
    end
endmodule // residual_overcurrent_trip_timer

// ---- sim/residual_overcurrent_trip_timer_asserts.sv ----
// concurrent checks on the ports of the residual overcurrent trip timer
module residual_overcurrent_trip_timer_asserts #(
    parameter int TICK_CYCLES = 150
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // measurement and block
    input wire logic [15:0] residualFundamentalMag,
    input wire logic blockInput,
    // decision outputs
    input wire logic startFlag,
    input wire logic tripFlag,
    input wire logic generalStartOut,
    input wire logic generalTripOut
);
    logic [31:0] startCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // length of the current start run; a dropout restarts it, as the delay counts do
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startCnt <= 32'h0;
        end else begin
            startCnt <= startFlag ? startCnt + 32'h1 : 32'h0;
        end
    end

    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_only_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    start_mag_a: assert property (startFlag |-> $past(residualFundamentalMag) > 16'h0050)
        else $error("start without magnitude above pickup");
    mag_drop_a: assert property (residualFundamentalMag == 16'h0000 |=> !startFlag)
        else $error("start held with zero magnitude");
    trip_start_a: assert property (tripFlag |-> startFlag)
        else $error("trip outside start");
    gen_start_a: assert property (generalStartOut |-> startFlag)
        else $error("general start without start");
    gen_trip_a: assert property (generalTripOut |-> tripFlag)
        else $error("general trip without trip");
    block_sup_a: assert property (blockInput [*6] |-> !startFlag && !tripFlag && !generalStartOut && !generalTripOut)
        else $error("outputs active while blocked");
    min_delay_a: assert property ($rose(tripFlag) |-> startCnt >= 39 * TICK_CYCLES)
        else $error("trip sooner than the minimum delay");
endmodule // residual_overcurrent_trip_timer_asserts

bind residual_overcurrent_trip_timer residual_overcurrent_trip_timer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .residualFundamentalMag(residualFundamentalMag), .blockInput(blockInput), .startFlag(startFlag),
    .tripFlag(tripFlag), .generalStartOut(generalStartOut), .generalTripOut(generalTripOut));

// ---- sim/meas_front_end.sv ----
// measurement chain and user block logic feeding the trip timer
module meas_front_end (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // commands from the bench
    input wire logic [15:0] magCmd,
    input wire logic blockCmd,
    // towards the timer
    output logic [15:0] residualFundamentalMag,
    output logic blockInput
);
    // one new fundamental magnitude per clock, block level from user logic; both registered like a real chain
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            residualFundamentalMag <= 16'h0000;
            blockInput <= 1'b0;
        end else begin
            residualFundamentalMag <= magCmd;
            blockInput <= blockCmd;
        end
    end
endmodule // meas_front_end

// ---- sim/residual_overcurrent_trip_timer_tb.sv ----
// self-checking bench for the residual overcurrent trip timer
`include "residual_overcurrent_defs.vh"
module residual_overcurrent_trip_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 150;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] magCmd = 16'h0000;
    logic blockCmd = 1'b0;
    wire [31:0] prdata;
    wire [15:0] residualFundamentalMag;
    wire pready, pslverr, blockInput, startFlag, tripFlag, generalStartOut, generalTripOut, irq;
    int bad_count = 0;
    int checks = 0;
    int cycCount = 0;

    meas_front_end u_fe (.clk_sys(clk_sys), .rst_n(rst_n), .magCmd(magCmd), .blockCmd(blockCmd),
        .residualFundamentalMag(residualFundamentalMag), .blockInput(blockInput));
    residual_overcurrent_trip_timer #(.TICK_CYCLES(T)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .residualFundamentalMag(residualFundamentalMag), .blockInput(blockInput),
        .startFlag(startFlag), .tripFlag(tripFlag), .generalStartOut(generalStartOut),
        .generalTripOut(generalTripOut), .irq(irq));

    // 20 MHz system clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // hang guard, only a few thousand cycles above the longest expected run
    always @(posedge clk_sys) begin
        cycCount <= cycCount + 1;
        if (cycCount == 99000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk("pready", 1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic set_mag(input logic [15:0] v);
        @(posedge clk_sys);
        magCmd <= v;
    endtask

    task automatic set_block(input logic v);
        @(posedge clk_sys);
        blockCmd <= v;
    endtask

    task automatic t_reset_vals();
        logic [7:0] a[9] = '{`ROC_OFS_CTRL, `ROC_OFS_PICKUP, `ROC_OFS_TMS, `ROC_OFS_MINDLY, `ROC_OFS_FIXDLY,
            `ROC_OFS_RSTDLY, `ROC_OFS_STATUS, `ROC_OFS_ISTAT, `ROC_OFS_IEN};
        logic [31:0] x[9] = '{0, 50, 100, 100, 100, 100, 0, 0, 0};
        logic [31:0] r;
        for (int i = 0; i < 9; i++) begin
            rd(a[i], r);
            chk("reset_value", x[i], r);
        end
    endtask

    // out-of-range writes are clamped, an oversize mode code stores off
    task automatic t_clamp();
        logic [7:0] a[12] = '{`ROC_OFS_PICKUP, `ROC_OFS_PICKUP, `ROC_OFS_TMS, `ROC_OFS_TMS, `ROC_OFS_MINDLY,
            `ROC_OFS_FIXDLY, `ROC_OFS_RSTDLY, `ROC_OFS_CTRL, `ROC_OFS_CTRL, `ROC_OFS_PICKUP, `ROC_OFS_CTRL,
            `ROC_OFS_PICKUP};
        logic [31:0] d[12] = '{3, 2000, 1, 20000, 10, 70000, 10, 'hf, 'h10, 3, 0, 50};
        logic [31:0] x[12] = '{10, 1000, 5, 1500, 40, 60000, 60, 0, 'h10, 5, 0, 50};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 12; i++) begin
            wr(a[i], d[i]);
            rd(a[i], r);
            chk("clamp", x[i], r);
        end
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped_err", 1, e);
        wr(`ROC_OFS_ACC, 32'hffff);
        rd(`ROC_OFS_ACC, r);
        chk("acc_readonly", 0, r);
        rd(`ROC_OFS_ICLR, r);
        chk("iclr_read", 0, r);
    endtask

    task automatic t_off();
        set_mag(16'd20000);
        cyc(20);
        chk("off_start", 0, startFlag);
        chk("off_trip", 0, tripFlag);
        set_mag(16'h0000);
        cyc(4);
    endtask

    task automatic t_fixed_irq();
        logic [31:0] r;
        int n;
        wr(`ROC_OFS_FIXDLY, 32'd40);
        wr(`ROC_OFS_IEN, 32'h3);
        wr(`ROC_OFS_CTRL, {28'h0, `ROC_MODE_FIXED});
        set_mag(16'd1000);
        cyc(4);
        chk("start", 1, startFlag);
        chk("gen_start", 1, generalStartOut);
        n = 0;
        while (tripFlag !== 1'b1 && n < 42 * T) begin
            @(posedge clk_sys);
            n++;
        end
        chk("fixed_not_early", 1, n >= 38 * T);
        chk("fixed_trip", 1, tripFlag);
        chk("gen_trip", 1, generalTripOut);
        cyc(2);
        chk("irq_set", 1, irq);
        rd(`ROC_OFS_ISTAT, r);
        chk("istat", 3, r);
        wr(`ROC_OFS_IEN, 32'h0);
        cyc(2);
        chk("irq_masked", 0, irq);
        wr(`ROC_OFS_IEN, 32'h3);
        cyc(2);
        chk("irq_unmasked", 1, irq);
        wr(`ROC_OFS_ICLR, 32'h3);
        cyc(2);
        chk("irq_cleared", 0, irq);
        rd(`ROC_OFS_ISTAT, r);
        chk("istat_cleared", 0, r);
    endtask

    // blocking in mid-trip drops everything; release restarts the delay from zero
    task automatic t_block();
        logic [31:0] r;
        set_block(1'b1);
        cyc(8);
        chk("blk_start", 0, startFlag);
        chk("blk_trip", 0, tripFlag);
        chk("blk_gstart", 0, generalStartOut);
        chk("blk_gtrip", 0, generalTripOut);
        rd(`ROC_OFS_STATUS, r);
        chk("blk_status", 32'h4, r);
        set_block(1'b0);
        cyc(8);
        chk("unblk_start", 1, startFlag);
        chk("unblk_trip", 0, tripFlag);
        set_mag(16'h0000);
        cyc(4);
        chk("drop_start", 0, startFlag);
        wr(`ROC_OFS_CTRL, 32'h0);
    endtask

    // every inverse curve at 25 times pickup, timed against the curve held at 20 times
    task automatic t_inverse();
        real kr[11] = '{0.14, 13.5, 80.0, 120.0, 0.0086, 0.0515, 19.61, 28.2, 0.086, 28.55, 64.07};
        real cc[11] = '{0.0, 0.0, 0.0, 0.0, 0.0185, 0.114, 0.491, 0.1217, 0.185, 0.712, 0.25};
        real al[11] = '{0.02, 1.0, 2.0, 1.0, 0.02, 0.02, 2.0, 2.0, 0.02, 2.0, 2.0};
        real ms;
        int lo, hi, lim, n;
        logic ok;
        wr(`ROC_OFS_TMS, 32'd5);
        wr(`ROC_OFS_MINDLY, 32'd40);
        for (int i = 0; i < 11; i++) begin
            wr(`ROC_OFS_CTRL, i + 2);
            ms = 50.0 * (kr[i] / (20.0 ** al[i] - 1.0) + cc[i]);
            if (ms < 40.0) ms = 40.0;
            lo = int'((0.9 * ms - 1.0) * T);
            hi = int'((1.1 * ms + 3.0) * T);
            lim = (hi < 56 * T) ? hi : 56 * T;
            set_mag(16'd20000);
            n = 0;
            while (tripFlag !== 1'b1 && n < lim) begin
                @(posedge clk_sys);
                n++;
            end
            ok = (hi <= 56 * T) ? (tripFlag === 1'b1 && n >= lo) : (tripFlag !== 1'b1);
            chk("curve_trip", 1, ok);
            set_mag(16'h0000);
            set_block(1'b1);
            cyc(8);
            set_block(1'b0);
            cyc(6);
        end
    endtask

    // fixed-reset curve keeps its progress through a short dropout, loses it after the reset delay
    task automatic t_iec_reset();
        logic [31:0] r;
        wr(`ROC_OFS_RSTDLY, 32'd60);
        wr(`ROC_OFS_CTRL, {28'h0, `ROC_MODE_FIRST_INV});
        set_mag(16'd20000);
        cyc(20 * T);
        set_mag(16'h0000);
        cyc(20 * T);
        rd(`ROC_OFS_ACC, r);
        chk("acc_held", 1, r != 32'h0);
        cyc(45 * T);
        rd(`ROC_OFS_ACC, r);
        chk("acc_cleared", 0, r);
        wr(`ROC_OFS_CTRL, 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_vals();
        t_clamp();
        t_off();
        t_fixed_irq();
        t_block();
        t_inverse();
        t_iec_reset();
        test_done();
    end
endmodule // residual_overcurrent_trip_timer_tb
